// ---- shared/mcv_pkg.sv ----
// constants shared by the multichannel valid stream ends
// Overview of operation
// - data meaningful only while valid high
// - channel is 8-bit id when valid
// - channel id travels with its data word
// - receiver decodes valid and channel, not latency
// - filter input valid acts as processing enable
// - source raises first valid only with real data
// - output data, valid, channel aligned same cycle
// - source presents data, valid, channel together
// - frame channels travel in consecutive cycles
// - source throttles only before channel zero
// - logic zero, adder/mux one, multiplier three stages
// - one datapath reused across time slots
// - slots per wire is floor(clock/sample)
// - channel counts zero to per-wire count minus one
// - unused slots carry valid low, channel don't-care
package mcv_pkg;
   localparam int CHAN_W = 8;                        // channel identifier width
   localparam int DATA_W = 16;                       // default data word width
   localparam int CLOCK_RATE_MHZ = 100;              // system clock rate
   localparam int SAMPLE_RATE_MHZ = 50;              // per-channel sample rate
   localparam int SLOTS_PER_PERIOD = CLOCK_RATE_MHZ / SAMPLE_RATE_MHZ; // floor division
   localparam int CHAN_COUNT = 2;                    // channels on one wire
   localparam int MUL_STAGES = 3;                    // multiplier register stages
   localparam int ADD_STAGES = 1;                    // adder register stages
   localparam int MUX_STAGES = 1;                    // multiplexer register stages
   localparam int PIPE_STAGES = MUL_STAGES + ADD_STAGES + MUX_STAGES; // total latency
   localparam logic [CHAN_W-1:0] CHAN_ZERO = 8'h00;  // first channel of a frame
endpackage

// ---- shared/mcv_if.sv ----
// stream interface carrying data, valid and channel between two ends
`timescale 1ns/1ps
interface mcv_if #(parameter int DW = 16) (input wire logic i_clk);
   logic [DW-1:0] data;   // sample word
   logic valid;           // word meaningful
   logic [7:0] channel;   // channel id
   modport source (input i_clk, output data, output valid, output channel);
   modport sink (input i_clk, input data, input valid, input channel);
endinterface

// ---- design/mcv_mac_pipe.sv ----
// folded multiply-accumulate pipeline that keeps channel tags with data
`timescale 1ns/1ps
module mcv_mac_pipe
   import mcv_pkg::*;
#(
   parameter int DW = DATA_W,
   parameter int NCH = CHAN_COUNT
) (
   input wire logic i_clk,                 // system clock
   input wire logic i_resetn,              // sync reset, active low
   input wire logic i_valid,               // sample enable
   input wire logic [DW-1:0] i_data,       // sample word
   input wire logic [CHAN_W-1:0] i_chan,   // sample channel
   input wire logic [DW-1:0] i_coef,       // gain coefficient
   input wire logic i_bypass,              // mux select: pass sample straight
   output logic o_valid,                   // result valid
   output logic [DW-1:0] o_data,           // result word
   output logic [CHAN_W-1:0] o_chan        // result channel
);
   localparam int PW = 2 * DW;
   // per-stage shift lines for the multiplier
   logic [PW-1:0] mul_r [MUL_STAGES];
   logic [DW-1:0] smp_r [MUL_STAGES];
   logic byp_r [MUL_STAGES];
   logic [CHAN_W-1:0] ch_r [MUL_STAGES];
   logic vl_r [MUL_STAGES];
   // per-channel accumulator memory, one slot per channel time share
   logic [DW-1:0] acc_r [NCH];
   logic [DW-1:0] sum_r, sum_nxt;
   logic [CHAN_W-1:0] sch_r;
   logic svl_r, sbyp_r;
   logic [DW-1:0] ssmp_r;
   logic [DW-1:0] out_r, out_nxt;
   logic [CHAN_W-1:0] och_r;
   logic ovl_r;
   logic [DW-1:0] prod_w;
   // product scaled back to word width
   always_comb begin
      prod_w = mul_r[MUL_STAGES-1][PW-2 -: DW];
      // accumulate into the slot of the word leaving the multiplier this cycle
      sum_nxt = acc_r[ch_r[MUL_STAGES-1][$clog2(NCH+1)-1:0] % NCH] + prod_w;
      out_nxt = sbyp_r ? ssmp_r : sum_r;
   end
   // multiplier stages, three registers deep
   always_ff @(posedge i_clk) begin
      for (int k = 0; k < MUL_STAGES; k++) begin
         if (k == 0) begin
            mul_r[k] <= PW'($signed(i_data) * $signed(i_coef));
            smp_r[k] <= i_data;
            byp_r[k] <= i_bypass;
            ch_r[k] <= i_chan;
            vl_r[k] <= i_resetn & i_valid;
         end else begin
            mul_r[k] <= mul_r[k-1];
            smp_r[k] <= smp_r[k-1];
            byp_r[k] <= byp_r[k-1];
            ch_r[k] <= ch_r[k-1];
            vl_r[k] <= i_resetn & vl_r[k-1];
         end
      end
   end
   // adder stage and per-channel accumulator update
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         svl_r <= 1'b0;
         sum_r <= '0;
         sch_r <= CHAN_ZERO;
         sbyp_r <= 1'b0;
         ssmp_r <= '0;
         for (int c = 0; c < NCH; c++) begin
            acc_r[c] <= '0;
         end
      end else begin
         svl_r <= vl_r[MUL_STAGES-1];
         sch_r <= ch_r[MUL_STAGES-1];
         sbyp_r <= byp_r[MUL_STAGES-1];
         ssmp_r <= smp_r[MUL_STAGES-1];
         sum_r <= sum_r;
         // state only advances on valid words so slower input rates stay correct
         if (vl_r[MUL_STAGES-1]) begin
            sum_r <= sum_nxt;
            acc_r[ch_r[MUL_STAGES-1][$clog2(NCH+1)-1:0] % NCH] <= sum_nxt;
         end
      end
   end
   // multiplexer stage, output all three signals from one register set
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         ovl_r <= 1'b0;
         out_r <= '0;
         och_r <= CHAN_ZERO;
      end else begin
         ovl_r <= svl_r;
         out_r <= out_nxt;
         och_r <= sch_r;
      end
   end
   assign o_valid = ovl_r;
   assign o_data = out_r;
   assign o_chan = och_r;
endmodule

// ---- design/mcv_device_end.sv ----
// device end: aligned input boundary, folded datapath, aligned output boundary
`timescale 1ns/1ps
module mcv_device_end
   import mcv_pkg::*;
#(
   parameter int DW = DATA_W,
   parameter int NCH = CHAN_COUNT
) (
   input wire logic i_clk,                 // system clock
   input wire logic i_resetn,              // sync reset, active low
   mcv_if.sink input_boundary,             // incoming stream
   mcv_if.source output_boundary,          // outgoing stream
   input wire logic [DW-1:0] i_coef,       // gain coefficient
   input wire logic i_bypass,              // pass samples without gain
   output logic o_frame_err                // frame not in consecutive cycles
);
   logic in_vl_r, in_vl_nxt;
   logic [DW-1:0] in_dt_r;
   logic [CHAN_W-1:0] in_ch_r;
   logic [CHAN_W-1:0] exp_r, exp_nxt;
   logic err_r, err_nxt;
   logic p_vl;
   logic [DW-1:0] p_dt;
   logic [CHAN_W-1:0] p_ch;
   logic vo_r;
   logic [DW-1:0] do_r;
   logic [CHAN_W-1:0] co_r;
   // input boundary capture; all three fields registered together
   always_comb begin
      in_vl_nxt = input_boundary.valid;
      exp_nxt = exp_r;
      err_nxt = err_r;
      // watch that frames arrive in consecutive cycles
      if (in_vl_r) begin
         if (in_ch_r != exp_r) begin
            err_nxt = 1'b1;
         end
         exp_nxt = (in_ch_r == CHAN_W'(NCH - 1)) ? CHAN_ZERO : in_ch_r + 8'h01;
      end else if (exp_r != CHAN_ZERO) begin
         err_nxt = 1'b1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         in_vl_r <= 1'b0;
         in_dt_r <= '0;
         in_ch_r <= CHAN_ZERO;
         exp_r <= CHAN_ZERO;
         err_r <= 1'b0;
      end else begin
         in_vl_r <= in_vl_nxt;
         in_dt_r <= input_boundary.data;
         in_ch_r <= input_boundary.channel;
         exp_r <= exp_nxt;
         err_r <= err_nxt;
      end
   end
   // folded datapath shared across channel slots
   mcv_mac_pipe #(.DW(DW), .NCH(NCH)) u_pipe (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_valid(in_vl_r),
      .i_data(in_dt_r),
      .i_chan(in_ch_r),
      .i_coef(i_coef),
      .i_bypass(i_bypass),
      .o_valid(p_vl),
      .o_data(p_dt),
      .o_chan(p_ch)
   );
   // output boundary register, keeping the three signals aligned
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         vo_r <= 1'b0;
         do_r <= '0;
         co_r <= CHAN_ZERO;
      end else begin
         vo_r <= p_vl;
         do_r <= p_dt;
         co_r <= p_ch;
      end
   end
   assign output_boundary.valid = vo_r;
   assign output_boundary.data = do_r;
   assign output_boundary.channel = co_r;
   assign o_frame_err = err_r;
endmodule

// ---- design/mcv_host_end.sv ----
// host end: source that slots channels into frames and sink that decodes them
`timescale 1ns/1ps
module mcv_host_end
   import mcv_pkg::*;
#(
   parameter int DW = DATA_W,
   parameter int NCH = CHAN_COUNT,
   parameter int SLOTS = SLOTS_PER_PERIOD
) (
   input wire logic i_clk,                 // system clock
   input wire logic i_resetn,              // sync reset, active low
   mcv_if.source input_boundary,           // stream toward device
   mcv_if.sink output_boundary,            // stream from device
   input wire logic i_smp_valid,           // user has real samples
   input wire logic [DW-1:0] i_smp_data,   // user sample word
   output logic o_smp_take,                // sample consumed this cycle
   output logic o_res_valid,               // decoded result valid
   output logic [DW-1:0] o_res_data,       // decoded result word
   output logic [CHAN_W-1:0] o_res_chan    // decoded result channel
);
   typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_GAP} src_state_t;
   src_state_t st_r, st_nxt;
   logic [CHAN_W-1:0] ch_r, ch_nxt;
   logic [CHAN_W-1:0] slot_r, slot_nxt;
   logic vl_r, vl_nxt;
   logic [DW-1:0] dt_r, dt_nxt;
   logic tk_r, tk_nxt;
   logic rv_r;
   logic [DW-1:0] rd_r;
   logic [CHAN_W-1:0] rc_r;
   logic open_slot;                        // period used up, next slot may open a frame
   // frame sequencer: channels back to back, then unused slots
   always_comb begin
      st_nxt = st_r;
      ch_nxt = ch_r;
      slot_nxt = slot_r;
      vl_nxt = 1'b0;
      dt_nxt = dt_r;
      tk_nxt = 1'b0;
      open_slot = 1'b0;
      unique case (st_r)
         ST_IDLE: begin
            open_slot = 1'b1;
         end
         ST_FRAME: begin
            if (ch_r == CHAN_W'(NCH - 1)) begin
               // last channel shown; leftover slots of the period stay unused
               if (slot_r >= CHAN_W'(SLOTS)) begin
                  open_slot = 1'b1;
               end else begin
                  st_nxt = ST_GAP;
                  slot_nxt = slot_r + 8'h01;
               end
            end else begin
               vl_nxt = 1'b1;
               dt_nxt = i_smp_data;
               tk_nxt = 1'b1;
               ch_nxt = ch_r + 8'h01;
               slot_nxt = slot_r + 8'h01;
            end
         end
         ST_GAP: begin
            if (slot_r >= CHAN_W'(SLOTS)) begin
               open_slot = 1'b1;
            end else begin
               slot_nxt = slot_r + 8'h01;
            end
         end
      endcase
      // only start, and only throttle, at channel zero
      if (open_slot) begin
         st_nxt = ST_IDLE;
         if (i_smp_valid) begin
            st_nxt = ST_FRAME;
            vl_nxt = 1'b1;
            dt_nxt = i_smp_data;
            tk_nxt = 1'b1;
            ch_nxt = CHAN_ZERO;
            slot_nxt = 8'h01;
         end
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         st_r <= ST_IDLE;
         ch_r <= CHAN_ZERO;
         slot_r <= 8'h00;
         vl_r <= 1'b0;
         dt_r <= '0;
         tk_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         ch_r <= ch_nxt;
         slot_r <= slot_nxt;
         vl_r <= vl_nxt;
         dt_r <= dt_nxt;
         tk_r <= tk_nxt;
      end
   end
   // drive all three fields from one register set
   assign input_boundary.valid = vl_r;
   assign input_boundary.data = dt_r;
   assign input_boundary.channel = ch_r;
   assign o_smp_take = tk_r;
   // sink decodes by valid and channel rather than latency counting
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         rv_r <= 1'b0;
         rd_r <= '0;
         rc_r <= CHAN_ZERO;
      end else begin
         rv_r <= output_boundary.valid;
         rd_r <= output_boundary.valid ? output_boundary.data : rd_r;
         rc_r <= output_boundary.valid ? output_boundary.channel : rc_r;
      end
   end
   assign o_res_valid = rv_r;
   assign o_res_data = rd_r;
   assign o_res_chan = rc_r;
endmodule

// ---- test/mcv_stream_chk.sv ----
// concurrent checks on the stream wires between host end and device end
`timescale 1ns/1ps
module mcv_stream_chk #(
   parameter int NCH = 2
) (
   input wire logic i_clk,             // system clock
   input wire logic i_resetn,          // sync reset, active low
   input wire logic in_valid,          // host to device valid
   input wire logic [7:0] in_channel,  // host to device channel
   input wire logic out_valid,         // device to host valid
   input wire logic [7:0] out_channel  // device to host channel
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   a_out_latency: assert property (in_valid |-> ##7 out_valid)
      else $error("output valid missing seven cycles after input");
   a_no_spurious: assert property (out_valid |-> $past(in_valid, 7))
      else $error("output valid without matching input");
   a_chan_kept: assert property (in_valid |-> ##7 (out_channel == $past(in_channel, 7)))
      else $error("channel changed through pipeline");
   a_out_range: assert property (out_valid |-> out_channel < NCH)
      else $error("output channel out of range");
   a_out_frame: assert property (out_valid && out_channel != NCH - 1 |=>
      out_valid && out_channel == $past(out_channel) + 8'h01)
      else $error("output frame not consecutive");
   a_in_frame: assert property (in_valid && in_channel != NCH - 1 |=>
      in_valid && in_channel == $past(in_channel) + 8'h01)
      else $error("input frame not consecutive");
   a_resume_zero: assert property ($rose(in_valid) |-> in_channel == 8'h00)
      else $error("input valid resumed off channel zero");
   a_out_start: assert property ($rose(out_valid) |-> out_channel == 8'h00)
      else $error("output run did not start at channel zero");
   a_reset_quiet: assert property (disable iff (1'b0) !i_resetn |=> !out_valid && !in_valid)
      else $error("valid high during reset");
   // main traffic shapes
   cover property (in_valid && in_channel == NCH - 1);
   cover property ($fell(in_valid));
   cover property (out_valid ##1 out_valid);
endmodule

// ---- test/tb_multichannel_valid_stream_port.sv ----
// self-checking bench joining host end and device end over two stream wires
`timescale 1ns/1ps
module tb_multichannel_valid_stream_port;
   import mcv_pkg::*;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [DATA_W-1:0] coef, smp, res_data;
   logic bypass, smp_valid, take, res_valid, frame_err, frame_err2;
   logic [CHAN_W-1:0] res_chan, wire_ch;
   logic [DATA_W-1:0] sent[$], got_d[$];
   logic [CHAN_W-1:0] got_c[$];
   int failures = 0;
   int cmp_count = 0;
   mcv_if #(.DW(DATA_W)) in_if (.i_clk(i_clk));
   mcv_if #(.DW(DATA_W)) out_if (.i_clk(i_clk));
   mcv_if #(.DW(DATA_W)) err_in_if (.i_clk(i_clk));
   mcv_if #(.DW(DATA_W)) err_out_if (.i_clk(i_clk));
   mcv_host_end mcv_host_end_i (.i_clk(i_clk), .i_resetn(i_resetn), .input_boundary(in_if),
      .output_boundary(out_if), .i_smp_valid(smp_valid), .i_smp_data(smp), .o_smp_take(take),
      .o_res_valid(res_valid), .o_res_data(res_data), .o_res_chan(res_chan));
   mcv_device_end mcv_device_end_i (.i_clk(i_clk), .i_resetn(i_resetn), .input_boundary(in_if),
      .output_boundary(out_if), .i_coef(coef), .i_bypass(bypass), .o_frame_err(frame_err));
   // second device end fed by a driver that breaks frame order on purpose
   mcv_device_end mcv_device_end_i2 (.i_clk(i_clk), .i_resetn(i_resetn),
      .input_boundary(err_in_if), .output_boundary(err_out_if), .i_coef(coef),
      .i_bypass(bypass), .o_frame_err(frame_err2));
   mcv_stream_chk #(.NCH(CHAN_COUNT)) mcv_stream_chk_i (.i_clk(i_clk), .i_resetn(i_resetn),
      .in_valid(in_if.valid), .in_channel(in_if.channel), .out_valid(out_if.valid),
      .out_channel(out_if.channel));
   // clock generator
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   // compare one value and count it
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // print counts and verdict, then stop
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // hold reset for 16 cycles, then check the wires are quiet
   task automatic do_reset();
      i_resetn = 1'b0;
      repeat (16) @(negedge i_clk);
      check("input valid in reset", in_if.valid, 1'b0);
      check("output valid in reset", out_if.valid, 1'b0);
      i_resetn = 1'b1;
   endtask
   // offer n samples, pausing at frame edges when hold is nonzero
   task automatic feed(input int n, input int hold);
      int k;
      int t;
      k = 0;
      t = 0;
      while (k < n && t < 1000) begin
         @(negedge i_clk);
         t++;
         if (take === 1'b1) begin
            sent.push_back(smp);
            k++;
            smp = smp + 16'h0013;
         end
         smp_valid = (k < n) && !(hold > 0 && k % 2 == 0 && t % 9 < hold);
      end
      smp_valid = 1'b0;
      repeat (20) @(negedge i_clk);
   endtask
   // wire monitor and result collector
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         wire_ch <= '0;
      end else begin
         if (in_if.valid === 1'b1) begin
            check("wire channel", in_if.channel, wire_ch);
            wire_ch <= (wire_ch == CHAN_W'(CHAN_COUNT - 1)) ? '0 : wire_ch + 1'b1;
         end
         if (res_valid === 1'b1) begin
            got_d.push_back(res_data);
            got_c.push_back(res_chan);
         end
      end
   end
   // compare collected results with pass-through or accumulated values
   task automatic check_results(input bit gain);
      logic [DATA_W-1:0] acc[CHAN_COUNT];
      logic [DATA_W-1:0] e;
      int p;
      check("result count", got_d.size(), sent.size());
      foreach (acc[c]) acc[c] = '0;
      for (int i = 0; i < got_d.size() && i < sent.size(); i++) begin
         p = ($signed(sent[i]) * $signed(coef)) >>> (DATA_W - 1);
         acc[i % CHAN_COUNT] = acc[i % CHAN_COUNT] + DATA_W'(p);
         e = gain ? acc[i % CHAN_COUNT] : sent[i];
         check("result data", got_d[i], e);
         check("result channel", got_c[i], i % CHAN_COUNT);
      end
      sent.delete();
      got_d.delete();
      got_c.delete();
   endtask
   // watchdog
   initial begin
      repeat (20000) @(posedge i_clk);
      failures++;
      final_report();
   end
   // main sequence
   initial begin
      coef = 16'h4000;
      bypass = 1'b1;
      smp_valid = 1'b0;
      smp = 16'h0100;
      err_in_if.valid = 1'b0;
      err_in_if.channel = '0;
      err_in_if.data = '0;
      do_reset();
      feed(10, 0);
      check_results(1'b0);
      feed(12, 3);
      check_results(1'b0);
      bypass = 1'b0;
      do_reset();
      feed(8, 0);
      check_results(1'b1);
      check("frame flag", frame_err, 1'b0);
      check("fault flag idle", frame_err2, 1'b0);
      @(negedge i_clk);
      err_in_if.valid = 1'b1;
      err_in_if.channel = 8'h01;
      @(negedge i_clk);
      err_in_if.valid = 1'b0;
      err_in_if.channel = 8'hfe;
      repeat (4) @(negedge i_clk);
      check("fault flag", frame_err2, 1'b1);
      final_report();
   end
endmodule
